// ===== design/ldcmd_consts.svh
// offsets, field positions, reset values and character codes of the command decoder
`ifndef LDCMD_CONSTS_SVH
`define LDCMD_CONSTS_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define LDCMD_ADDR_W 8
`define LDCMD_A_EVT_STAT 8'h00
`define LDCMD_A_EVT_MASK 8'h04
`define LDCMD_A_STATE 8'h08
`define LDCMD_A_FAULT_LATCH 8'h0C
`define LDCMD_A_ERR_WORD 8'h10
`define LDCMD_A_CTRL 8'h14

// ----------------------------------------
// event bits
// ----------------------------------------
`define LDCMD_EVT_W 5
`define LDCMD_EVT_SET_DONE 0
`define LDCMD_EVT_REPLY_DONE 1
`define LDCMD_EVT_BAD_CMD 2
`define LDCMD_EVT_WIPE 3
`define LDCMD_EVT_FAULT 4

// ----------------------------------------
// state readback field positions
// ----------------------------------------
`define LDCMD_F_MODE_LO 0
`define LDCMD_F_SHORT 2
`define LDCMD_F_PRESET 3
`define LDCMD_F_SENSE 4
`define LDCMD_F_LEVEL 5
`define LDCMD_F_DYN 6

// ----------------------------------------
// reset values
// ----------------------------------------
`define LDCMD_RST_MASK 5'h00
`define LDCMD_RST_CTRL 1'b1
`define LDCMD_RST_MODE 2'h0

// ----------------------------------------
// characters and token size
// ----------------------------------------
`define LDCMD_TOK_W 64
`define LDCMD_TOK_MAX 4'h8
`define LDCMD_CH_SEMI 8'h3B
`define LDCMD_CH_NL 8'h0A
`define LDCMD_CH_SP 8'h20
`define LDCMD_CH_COLON 8'h3A
`define LDCMD_CH_QUERY 8'h3F
`define LDCMD_CH_LC_A 8'h61
`define LDCMD_CH_LC_Z 8'h7A
`define LDCMD_CH_CASE 8'h20
`define LDCMD_CH_ZERO 8'h30
`define LDCMD_DYN_CODE_ON 2'h1
`define LDCMD_DYN_CODE_OFF 2'h2

`endif

// ===== design/ldcmd_pkg.sv
// types shared by the command decoder files
package ldcmd_pkg;

   typedef enum logic [4:0] {
      W_NONE, W_STAT, W_MODE, W_SHORT, W_PRESET, W_SENSE, W_LEVEL, W_DYN, W_CLR,
      W_CC, W_CR, W_CV, W_CP, W_ON, W_OFF, W_AUTO, W_HIGH, W_LOW
   } ldcmd_word_e;

   typedef enum logic [1:0] {
      constant_current, constant_resistance, constant_voltage, constant_power
   } ldcmd_mode_e;

   typedef enum logic [2:0] {
      ST_KEY, ST_ARG, ST_QEND, ST_SKIP, ST_REPLY
   } ldcmd_state_e;

endpackage : ldcmd_pkg

// ===== design/ldcmd_word_match.sv
// maps a right-aligned upper-case token to a keyword or argument code
`timescale 1ns/10ps
`default_nettype none
`include "ldcmd_consts.svh"

module ldcmd_word_match (
   // token
   input wire logic [`LDCMD_TOK_W-1:0] i_tok,
   // decoded word
   output ldcmd_pkg::ldcmd_word_e o_word
);
   import ldcmd_pkg::*;

   // short and long keyword forms are accepted where both exist; MODE and CLR have one form only
   always_comb begin
      case (i_tok)
         {32'h0, "STAT"}, {24'h0, "STATE"}: o_word = W_STAT;
         {32'h0, "MODE"}: o_word = W_MODE;
         {32'h0, "SHOR"}, {24'h0, "SHORT"}: o_word = W_SHORT;
         {32'h0, "PRES"}, {16'h0, "PRESET"}: o_word = W_PRESET;
         {32'h0, "SENS"}, {24'h0, "SENSE"}: o_word = W_SENSE;
         {40'h0, "LEV"}, {24'h0, "LEVEL"}: o_word = W_LEVEL;
         {40'h0, "DYN"}, {8'h0, "DYNAMIC"}: o_word = W_DYN;
         {40'h0, "CLR"}: o_word = W_CLR;
         {48'h0, "CC"}: o_word = W_CC;
         {48'h0, "CR"}: o_word = W_CR;
         {48'h0, "CV"}: o_word = W_CV;
         {48'h0, "CP"}: o_word = W_CP;
         {48'h0, "ON"}: o_word = W_ON;
         {40'h0, "OFF"}: o_word = W_OFF;
         {32'h0, "AUTO"}: o_word = W_AUTO;
         {32'h0, "HIGH"}: o_word = W_HIGH;
         {40'h0, "LOW"}: o_word = W_LOW;
         default: o_word = W_NONE;
      endcase
   end

endmodule : ldcmd_word_match
`default_nettype wire

// ===== design/ldcmd_decoder.sv
// text command decoder for the load state fields, with register port and interrupt
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "ldcmd_consts.svh"

module ldcmd_decoder (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // command byte stream from the host link
   input wire logic [7:0] i_rx_data,
   input wire logic i_rx_valid,
   output logic o_rx_ready,
   // reply byte stream to the host link
   output logic [7:0] o_tx_data,
   output logic o_tx_valid,
   input wire logic i_tx_ready,
   // fault and error sources
   input wire logic [7:0] i_fault_set,
   input wire logic [7:0] i_err_set,
   // state fields
   output ldcmd_pkg::ldcmd_mode_e o_mode,
   output logic o_short_on,
   output logic o_preset_on,
   output logic o_sense_on,
   output logic o_level_high,
   output logic o_dyn_on,
   output logic [7:0] o_fault_latch_word,
   output logic [7:0] o_err_word,
   // register port
   input wire logic [`LDCMD_ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   // interrupt
   output logic o_irq
);
   import ldcmd_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      ldcmd_state_e st;
      logic [`LDCMD_TOK_W-1:0] tok;
      logic [3:0] cnt;
      logic prefix;
      ldcmd_word_e kw;
      ldcmd_mode_e mode;
      logic short_on;
      logic preset_on;
      logic sense_on;
      logic level_high;
      logic dyn_on;
      logic [7:0] fault;
      logic [7:0] err;
      logic [7:0] tx_data;
      logic tx_valid;
      logic tx_last;
      logic rx_ready;
      logic [`LDCMD_EVT_W-1:0] stat;
      logic [`LDCMD_EVT_W-1:0] mask;
      logic ctrl_en;
      logic [31:0] rdata;
      logic irq;
   } ldcmd_regs_s;

   ldcmd_regs_s state_ff;
   ldcmd_regs_s nxt_state;
   ldcmd_word_e word;

   ldcmd_word_match u_match (
      .i_tok(state_ff.tok),
      .o_word(word)
   );

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      logic [7:0] ch;
      logic take;
      logic term;
      logic wipe;
      logic [`LDCMD_EVT_W-1:0] ev;
      logic [1:0] code;
      ch = i_rx_data;
      take = i_rx_valid && state_ff.rx_ready;
      term = 1'b0;
      wipe = 1'b0;
      ev = '0;
      code = 2'h0;
      nxt_state = state_ff;
      nxt_state.rdata = 32'h0000_0000;
      // upper case so keywords match in either case
      if (ch >= `LDCMD_CH_LC_A && ch <= `LDCMD_CH_LC_Z) begin
         ch = ch - `LDCMD_CH_CASE;
      end
      // semicolon or newline ends a command
      term = (ch == `LDCMD_CH_SEMI) || (ch == `LDCMD_CH_NL);

      case (state_ff.st)
         ST_KEY: begin
            if (take) begin
               if (term) begin
                  nxt_state.tok = '0;
                  nxt_state.cnt = 4'h0;
                  nxt_state.prefix = 1'b0;
                  if (state_ff.cnt != 4'h0 || state_ff.prefix) begin
                     if (word == W_CLR) begin
                        wipe = 1'b1;
                        ev[`LDCMD_EVT_WIPE] = 1'b1;
                     end else begin
                        ev[`LDCMD_EVT_BAD_CMD] = 1'b1;
                     end
                  end
               end else if (ch == `LDCMD_CH_COLON) begin
                  if (word == W_STAT && !state_ff.prefix) begin
                     nxt_state.prefix = 1'b1;
                     nxt_state.tok = '0;
                     nxt_state.cnt = 4'h0;
                  end else begin
                     nxt_state.st = ST_SKIP;
                     ev[`LDCMD_EVT_BAD_CMD] = 1'b1;
                  end
               end else if (ch == `LDCMD_CH_SP) begin
                  // leading blanks are ignored
                  if (state_ff.cnt != 4'h0) begin
                     if (word inside {W_MODE, W_SHORT, W_PRESET, W_SENSE, W_LEVEL, W_DYN}) begin
                        nxt_state.kw = word;
                        nxt_state.st = ST_ARG;
                        nxt_state.tok = '0;
                        nxt_state.cnt = 4'h0;
                     end else begin
                        nxt_state.st = ST_SKIP;
                        ev[`LDCMD_EVT_BAD_CMD] = 1'b1;
                     end
                  end
               end else if (ch == `LDCMD_CH_QUERY) begin
                  if (word inside {W_MODE, W_SHORT, W_PRESET, W_SENSE, W_LEVEL, W_DYN}) begin
                     nxt_state.kw = word;
                     nxt_state.st = ST_QEND;
                  end else begin
                     nxt_state.st = ST_SKIP;
                     ev[`LDCMD_EVT_BAD_CMD] = 1'b1;
                  end
               end else if (state_ff.cnt == `LDCMD_TOK_MAX) begin
                  // too long for any keyword
                  nxt_state.st = ST_SKIP;
                  ev[`LDCMD_EVT_BAD_CMD] = 1'b1;
               end else begin
                  nxt_state.tok = {state_ff.tok[`LDCMD_TOK_W-9:0], ch};
                  nxt_state.cnt = state_ff.cnt + 4'h1;
               end
            end
         end

         ST_ARG: begin
            if (take) begin
               if (term) begin
                  nxt_state.st = ST_KEY;
                  nxt_state.tok = '0;
                  nxt_state.cnt = 4'h0;
                  nxt_state.prefix = 1'b0;
                  ev[`LDCMD_EVT_SET_DONE] = 1'b1;
                  case (state_ff.kw)
                     W_MODE: begin
                        case (word)
                           W_CC: nxt_state.mode = constant_current;
                           W_CR: nxt_state.mode = constant_resistance;
                           W_CV: nxt_state.mode = constant_voltage;
                           W_CP: nxt_state.mode = constant_power;
                           default: ev = 5'h04;
                        endcase
                     end
                     W_SHORT: begin
                        if (word == W_ON || word == W_OFF) begin
                           nxt_state.short_on = (word == W_ON);
                        end else begin
                           ev = 5'h04;
                        end
                     end
                     W_PRESET: begin
                        if (word == W_ON || word == W_OFF) begin
                           nxt_state.preset_on = (word == W_ON);
                        end else begin
                           ev = 5'h04;
                        end
                     end
                     W_SENSE: begin
                        // rear sense only or auto fallback
                        if (word == W_ON || word == W_AUTO) begin
                           nxt_state.sense_on = (word == W_ON);
                        end else begin
                           ev = 5'h04;
                        end
                     end
                     W_LEVEL: begin
                        if (word == W_HIGH || word == W_LOW) begin
                           nxt_state.level_high = (word == W_HIGH);
                        end else begin
                           ev = 5'h04;
                        end
                     end
                     W_DYN: begin
                        if (word == W_ON || word == W_OFF) begin
                           nxt_state.dyn_on = (word == W_ON);
                        end else begin
                           ev = 5'h04;
                        end
                     end
                     default: ev = 5'h04;
                  endcase
               end else if (ch == `LDCMD_CH_SP) begin
                  // blank inside an argument is malformed
                  if (state_ff.cnt != 4'h0) begin
                     nxt_state.st = ST_SKIP;
                     ev[`LDCMD_EVT_BAD_CMD] = 1'b1;
                  end
               end else if (state_ff.cnt == `LDCMD_TOK_MAX) begin
                  nxt_state.st = ST_SKIP;
                  ev[`LDCMD_EVT_BAD_CMD] = 1'b1;
               end else begin
                  nxt_state.tok = {state_ff.tok[`LDCMD_TOK_W-9:0], ch};
                  nxt_state.cnt = state_ff.cnt + 4'h1;
               end
            end
         end

         ST_QEND: begin
            if (take) begin
               nxt_state.tok = '0;
               nxt_state.cnt = 4'h0;
               nxt_state.prefix = 1'b0;
               if (term) begin
                  // reply only once the query is complete
                  case (state_ff.kw)
                     W_MODE: code = state_ff.mode;
                     W_SHORT: code = {1'b0, state_ff.short_on};
                     W_PRESET: code = {1'b0, state_ff.preset_on};
                     W_SENSE: code = {1'b0, state_ff.sense_on};
                     W_LEVEL: code = {1'b0, state_ff.level_high};
                     W_DYN: code = state_ff.dyn_on ? `LDCMD_DYN_CODE_ON : `LDCMD_DYN_CODE_OFF;
                     default: code = 2'h0;
                  endcase
                  nxt_state.tx_data = `LDCMD_CH_ZERO + {6'h00, code};
                  nxt_state.tx_valid = 1'b1;
                  nxt_state.tx_last = 1'b0;
                  nxt_state.rx_ready = 1'b0;
                  nxt_state.st = ST_REPLY;
               end else begin
                  nxt_state.st = ST_SKIP;
                  ev[`LDCMD_EVT_BAD_CMD] = 1'b1;
               end
            end
         end

         ST_SKIP: begin
            if (take && term) begin
               nxt_state.st = ST_KEY;
               nxt_state.tok = '0;
               nxt_state.cnt = 4'h0;
               nxt_state.prefix = 1'b0;
            end
         end

         ST_REPLY: begin
            // digit then newline, each held until taken
            if (state_ff.tx_valid && i_tx_ready) begin
               if (!state_ff.tx_last) begin
                  nxt_state.tx_data = `LDCMD_CH_NL;
                  nxt_state.tx_last = 1'b1;
               end else begin
                  nxt_state.tx_valid = 1'b0;
                  nxt_state.tx_last = 1'b0;
                  nxt_state.st = ST_KEY;
                  ev[`LDCMD_EVT_REPLY_DONE] = 1'b1;
               end
            end
         end

         default: nxt_state.st = ST_KEY;
      endcase

      // input is stalled while a reply is out or software halts parsing
      nxt_state.rx_ready = state_ff.ctrl_en && (nxt_state.st != ST_REPLY);

      // wipe clears both words; a new fault in that cycle still lands
      nxt_state.fault = (wipe ? 8'h00 : state_ff.fault) | i_fault_set;
      nxt_state.err = (wipe ? 8'h00 : state_ff.err) | i_err_set;
      if ((i_fault_set | i_err_set) != 8'h00) begin
         ev[`LDCMD_EVT_FAULT] = 1'b1;
      end

      // ----------------------------------------
      // register port
      // ----------------------------------------
      nxt_state.stat = state_ff.stat | ev;
      if (i_wr) begin
         case (i_addr)
            `LDCMD_A_EVT_STAT: nxt_state.stat = (state_ff.stat & ~i_wdata[`LDCMD_EVT_W-1:0]) | ev;
            `LDCMD_A_EVT_MASK: nxt_state.mask = i_wdata[`LDCMD_EVT_W-1:0];
            `LDCMD_A_CTRL: nxt_state.ctrl_en = i_wdata[0];
            default: nxt_state.ctrl_en = state_ff.ctrl_en;
         endcase
      end
      if (i_rd) begin
         case (i_addr)
            `LDCMD_A_EVT_STAT: nxt_state.rdata = {27'h0, state_ff.stat};
            `LDCMD_A_EVT_MASK: nxt_state.rdata = {27'h0, state_ff.mask};
            `LDCMD_A_STATE: nxt_state.rdata = {25'h0, state_ff.dyn_on, state_ff.level_high,
               state_ff.sense_on, state_ff.preset_on, state_ff.short_on, state_ff.mode};
            `LDCMD_A_FAULT_LATCH: nxt_state.rdata = {24'h0, state_ff.fault};
            `LDCMD_A_ERR_WORD: nxt_state.rdata = {24'h0, state_ff.err};
            `LDCMD_A_CTRL: nxt_state.rdata = {31'h0, state_ff.ctrl_en};
            default: nxt_state.rdata = 32'h0000_0000;
         endcase
      end
      nxt_state.irq = |(nxt_state.stat & nxt_state.mask);
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_ff <= '{st: ST_KEY, tok: '0, cnt: 4'h0, prefix: 1'b0, kw: W_NONE,
            mode: constant_current, short_on: 1'b0, preset_on: 1'b0, sense_on: 1'b0,
            level_high: 1'b0, dyn_on: 1'b0, fault: 8'h00, err: 8'h00, tx_data: 8'h00,
            tx_valid: 1'b0, tx_last: 1'b0, rx_ready: 1'b0, stat: 5'h00,
            mask: `LDCMD_RST_MASK, ctrl_en: `LDCMD_RST_CTRL, rdata: 32'h0000_0000,
            irq: 1'b0};
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign o_rx_ready = state_ff.rx_ready;
   assign o_tx_data = state_ff.tx_data;
   assign o_tx_valid = state_ff.tx_valid;
   assign o_mode = state_ff.mode;
   assign o_short_on = state_ff.short_on;
   assign o_preset_on = state_ff.preset_on;
   assign o_sense_on = state_ff.sense_on;
   assign o_level_high = state_ff.level_high;
   assign o_dyn_on = state_ff.dyn_on;
   assign o_fault_latch_word = state_ff.fault;
   assign o_err_word = state_ff.err;
   assign o_rdata = state_ff.rdata;
   assign o_irq = state_ff.irq;

endmodule : ldcmd_decoder
`default_nettype wire

// ===== verif/ldcmd_decoder_asserts.sv
// assertion checker bound to the command decoder ports
`timescale 1ns/10ps
`default_nettype none
module ldcmd_decoder_asserts (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // byte links
   input wire logic [7:0] i_rx_data,
   input wire logic i_rx_valid,
   input wire logic o_rx_ready,
   input wire logic [7:0] o_tx_data,
   input wire logic o_tx_valid,
   input wire logic i_tx_ready,
   // sources and state
   input wire logic [7:0] i_fault_set,
   input wire logic [7:0] i_err_set,
   input wire ldcmd_pkg::ldcmd_mode_e o_mode,
   input wire logic o_short_on,
   input wire logic o_preset_on,
   input wire logic o_sense_on,
   input wire logic o_level_high,
   input wire logic o_dyn_on,
   input wire logic [7:0] o_fault_latch_word,
   input wire logic [7:0] o_err_word
);
   import ldcmd_pkg::*;
   logic term_tk;
   logic [6:0] st;
   assign term_tk = i_rx_valid && o_rx_ready && (i_rx_data == 8'h3B || i_rx_data == 8'h0A);
   assign st = {o_dyn_on, o_level_high, o_sense_on, o_preset_on, o_short_on, o_mode};
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   property p_reply_after_term;
      $rose(o_tx_valid) |-> $past(term_tk);
   endproperty
   a_reply_after_term: assert property (p_reply_after_term)
      else $error("reply started without a terminator");
   property p_digit_then_nl;
      o_tx_valid && i_tx_ready && o_tx_data != 8'h0A |=> o_tx_valid && o_tx_data == 8'h0A;
   endproperty
   a_digit_then_nl: assert property (p_digit_then_nl)
      else $error("reply digit not followed by newline");
   property p_reply_hold;
      o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data);
   endproperty
   a_reply_hold: assert property (p_reply_hold)
      else $error("reply byte dropped while stalled");
   property p_code_range;
      o_tx_valid |-> o_tx_data inside {[8'h30:8'h33], 8'h0A};
   endproperty
   a_code_range: assert property (p_code_range)
      else $error("reply byte outside code range");
   property p_no_rx_in_reply;
      o_tx_valid |-> !o_rx_ready;
   endproperty
   a_no_rx_in_reply: assert property (p_no_rx_in_reply)
      else $error("command bytes accepted during reply");
   property p_state_on_term;
      !$stable(st) |-> $past(term_tk);
   endproperty
   a_state_on_term: assert property (p_state_on_term)
      else $error("state changed without a complete command");
   property p_fault_wipe;
      ($past(o_fault_latch_word) & ~o_fault_latch_word) != 8'h00 |-> $past(term_tk);
   endproperty
   a_fault_wipe: assert property (p_fault_wipe)
      else $error("fault word cleared without a command");
   property p_fault_set;
      i_fault_set != 8'h00 |=> (o_fault_latch_word & $past(i_fault_set)) == $past(i_fault_set);
   endproperty
   a_fault_set: assert property (p_fault_set)
      else $error("fault input not latched");
   property p_err_set;
      i_err_set != 8'h00 |=> (o_err_word & $past(i_err_set)) == $past(i_err_set);
   endproperty
   a_err_set: assert property (p_err_set)
      else $error("error input not latched");
endmodule : ldcmd_decoder_asserts
bind ldcmd_decoder ldcmd_decoder_asserts u_chk (.i_mclk, .i_rst_n, .i_rx_data, .i_rx_valid,
   .o_rx_ready, .o_tx_data, .o_tx_valid, .i_tx_ready, .i_fault_set, .i_err_set, .o_mode,
   .o_short_on, .o_preset_on, .o_sense_on, .o_level_high, .o_dyn_on, .o_fault_latch_word,
   .o_err_word);
`default_nettype wire

// ===== verif/ldcmd_host_model.sv
// remote host model: sends command text, collects reply bytes
`timescale 1ns/10ps
`default_nettype none
module ldcmd_host_model (
   // clock
   input wire logic i_mclk,
   // command stream
   output logic [7:0] o_rx_data,
   output logic o_rx_valid,
   input wire logic i_rx_ready,
   // reply stream
   input wire logic [7:0] i_tx_data,
   input wire logic i_tx_valid,
   output logic o_tx_ready
);
   logic slow = 1'b0;
   logic [7:0] rq[$];
   initial begin
      o_rx_data = 8'h00;
      o_rx_valid = 1'b0;
      o_tx_ready = 1'b0;
   end
   // slow host stalls every other cycle so held replies get exercised
   always @(posedge i_mclk) begin
      o_tx_ready <= slow ? !o_tx_ready : 1'b1;
      if (i_tx_valid && o_tx_ready) begin
         rq.push_back(i_tx_data);
      end
   end
   task send(input string s);
      for (int i = 0; i < s.len(); i++) begin
         o_rx_valid <= 1'b1;
         o_rx_data <= s[i];
         do @(posedge i_mclk); while (i_rx_ready !== 1'b1);
      end
      o_rx_valid <= 1'b0;
      // released data shows the inverse, never a stale byte
      o_rx_data <= ~o_rx_data;
      @(posedge i_mclk);
   endtask : send
endmodule : ldcmd_host_model
`default_nettype wire

// ===== verif/tb_ldcmd_decoder.sv
// self-checking bench for the command decoder
`timescale 1ns/10ps
`default_nettype none
module tb_ldcmd_decoder;
   import ldcmd_pkg::*;
   logic i_mclk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [7:0] rx_data, tx_data, addr = 8'h00, fault_set = 8'h00, err_set = 8'h00;
   logic rx_valid, rx_ready, tx_valid, tx_ready, reg_wr = 1'b0, reg_rd = 1'b0, irq;
   logic [31:0] wdata = 32'h0, rdata, v;
   ldcmd_mode_e mode;
   logic short_on, preset_on, sense_on, level_high, dyn_on;
   logic [7:0] fault_w, err_w;
   int mismatches = 0;
   int samples_checked = 0;
   int cyc = 0;
   ldcmd_decoder u_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_rx_data(rx_data),
      .i_rx_valid(rx_valid), .o_rx_ready(rx_ready), .o_tx_data(tx_data),
      .o_tx_valid(tx_valid), .i_tx_ready(tx_ready), .i_fault_set(fault_set),
      .i_err_set(err_set), .o_mode(mode), .o_short_on(short_on), .o_preset_on(preset_on),
      .o_sense_on(sense_on), .o_level_high(level_high), .o_dyn_on(dyn_on),
      .o_fault_latch_word(fault_w), .o_err_word(err_w), .i_addr(addr), .i_wdata(wdata),
      .i_wr(reg_wr), .i_rd(reg_rd), .o_rdata(rdata), .o_irq(irq));
   ldcmd_host_model u_host (.i_mclk(i_mclk), .o_rx_data(rx_data), .o_rx_valid(rx_valid),
      .i_rx_ready(rx_ready), .i_tx_data(tx_data), .i_tx_valid(tx_valid),
      .o_tx_ready(tx_ready));
   always #2 i_mclk = ~i_mclk;
   // the whole run needs a few hundred cycles
   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         end_of_test();
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] d);
      reg_wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge i_mclk);
      reg_wr <= 1'b0;
      @(posedge i_mclk);
   endtask : wr
   task rd(input logic [7:0] a, output logic [31:0] d);
      reg_rd <= 1'b1;
      addr <= a;
      @(posedge i_mclk);
      reg_rd <= 1'b0;
      @(negedge i_mclk);
      d = rdata;
      @(posedge i_mclk);
   endtask : rd
   task chk_reply(input logic [7:0] code);
      for (int i = 0; i < 60 && u_host.rq.size() < 2; i++) @(posedge i_mclk);
      if (u_host.rq.size() != 2) begin
         chk(u_host.rq.size(), 2);
      end else begin
         chk({u_host.rq[0], u_host.rq[1]}, {8'h30 + code, 8'h0A});
      end
      u_host.rq.delete();
   endtask : chk_reply
   task setq(input string key, input string arg, input logic [7:0] code,
      input logic [31:0] bits);
      u_host.send({key, " ", arg, ";"});
      chk({25'h0, dyn_on, level_high, sense_on, preset_on, short_on, mode}, bits);
      u_host.send({key, "?\n"});
      chk_reply(code);
   endtask : setq
   task t_reset();
      rd(8'h14, v);
      chk(v, 32'h1);
      rd(8'h04, v);
      chk(v, 32'h0);
      rd(8'h08, v);
      chk(v, 32'h0);
      // unmapped place reads zero
      rd(8'h18, v);
      chk(v, 32'h0);
      wr(8'h14, 32'h0);
      // ready follows the stored enable, so it falls one edge after the write lands
      @(posedge i_mclk);
      chk(rx_ready, 1'b0);
      wr(8'h14, 32'h1);
   endtask : t_reset
   task t_mode();
      string m[4] = '{"CC", "CR", "CV", "CP"};
      string pre;
      for (int i = 0; i < 4; i++) begin
         // string variable keeps the empty prefix from turning into a null byte
         if (i % 2) begin
            pre = "STATE:";
         end else begin
            pre = "";
         end
         u_host.send({pre, "MODE ", m[i], "\n"});
         chk(mode, i[1:0]);
         u_host.send("stat:mode?;");
         chk_reply(8'(i));
      end
   endtask : t_mode
   task t_flags();
      setq("SHORT", "ON", 8'h1, 32'h07);
      setq("SHOR", "OFF", 8'h0, 32'h03);
      setq("PRESET", "ON", 8'h1, 32'h0B);
      setq("SENSE", "ON", 8'h1, 32'h1B);
      setq("SENS", "AUTO", 8'h0, 32'h0B);
      setq("LEVEL", "HIGH", 8'h1, 32'h2B);
      setq("LEV", "LOW", 8'h0, 32'h0B);
      u_host.slow <= 1'b1;
      setq("DYNAMIC", "ON", 8'h1, 32'h4B);
      setq("DYN", "OFF", 8'h2, 32'h0B);
      u_host.slow <= 1'b0;
      setq("PRES", "OFF", 8'h0, 32'h03);
   endtask : t_flags
   task t_bad();
      u_host.send("MODE XX;");
      u_host.send("FOO?\n");
      u_host.send("CLR?\n");
      u_host.send("SHORT ON ;");
      repeat (10) @(posedge i_mclk);
      chk(u_host.rq.size(), 0);
      rd(8'h08, v);
      chk(v, 32'h03);
      rd(8'h00, v);
      chk(v & 32'h4, 32'h4);
   endtask : t_bad
   task t_irq();
      wr(8'h00, 32'h1F);
      fault_set <= 8'h05;
      err_set <= 8'hA0;
      @(posedge i_mclk);
      fault_set <= 8'h00;
      err_set <= 8'h00;
      repeat (2) @(posedge i_mclk);
      chk(irq, 1'b0);
      wr(8'h04, 32'h10);
      chk({fault_w, err_w, 15'h0, irq}, {8'h05, 8'hA0, 16'h1});
      u_host.send("STAT:CLR;");
      chk({fault_w, err_w}, 16'h0);
      rd(8'h00, v);
      chk(v & 32'h18, 32'h18);
      wr(8'h00, 32'h1F);
      rd(8'h00, v);
      chk({v, 7'h0, irq}, 40'h0);
   endtask : t_irq
   task end_of_test();
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_of_test
   initial begin
      repeat (12) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_mclk);
      t_reset();
      t_mode();
      t_flags();
      t_bad();
      t_irq();
      end_of_test();
   end
endmodule : tb_ldcmd_decoder
`default_nettype wire
